//--- fcif_top.sv
// Fuse control and host port configuration page: registers, reload sequencer,
// fuse unlock path and host port decode. Assumes the register port and fuse
// array run on clk; the four-wire pins are asynchronous.
//
// Overview of operation
// - Identification registers writable only without write-disable
// - Config lock flag blocks fusing config range
// - Application lock flag blocks fusing application range
// - Device lock flag blocks fusing device range
// - Software sets done; leaving emulation clears it
// - Application trigger reloads its registers and lock
// - Device trigger reloads write-disable and device lock
// - Timing bit selects normal or marginal reads
// - Eight-bit fuse address register, read and write
// - Data register; select plus three unlock bytes
// - Signed temperature offset loaded from fuses
// - Power-manager port answers base plus page bit
// - High-speed port answers base plus four
// - Base zero means hardware default address
// - Direction polarity bit defines read indication
// - Clock polarity bit selects idle level
// - Host configuration writable unmarked and unlocked only
// - Page control mirrors page-zero control register
// - Interface type bit reports two-wire or four-wire
`timescale 1ns/1ps
module fcif_top
	import fcif_pkg::*;
#(
	parameter logic [3:0] DEFAULT_BASE = 4'hB
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [8:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// Fuse array read port
	output logic fuseRdReq,
	output logic [7:0] fuseRdAddr,
	output logic fuseMarginal,
	input wire logic fuseRdAck,
	input wire logic [7:0] fuseRdData,
	// Fuse programming path
	output logic [7:0] fuseAddrOut,
	output logic [7:0] fuseDataOut,
	output logic fuseSelectPulse,
	output logic fuseUnlocked,
	output logic fuseProgram,
	output logic fuseProgramRefused,
	// System status
	input wire logic emulatedReadActive,
	input wire logic unmarkedSample,
	output logic reloadBusy,
	output logic identWriteEnable,
	output logic [7:0] pageControl,
	// Two-wire address decode
	input wire logic [7:0] rxSlaveAddr,
	input wire logic rxSlaveAddrValid,
	output logic pmHit,
	output logic hsHit,
	output logic slaveRead,
	output logic slavePageHigh,
	// Four-wire pins and decode
	input wire logic fwSelectPin,
	input wire logic fwDirPin,
	input wire logic fwClkPin,
	output logic fwSelected,
	output logic fwIsRead,
	output logic fwClkIdle,
	output logic fwClkPhase,
	output logic ifTypeTwoWire
);

	// Whole state of the block
	typedef struct packed
	{
		fcif_seq_type seq;
		fcif_mode_type mode;
		logic [1:0] step;
		logic req;
		logic [7:0] rdAddr;
		logic [7:0] page;
		logic [7:0] locks;
		logic done;
		logic appTrig;
		logic devTrig;
		logic timing;
		logic [7:0] fAddr;
		logic [7:0] fData;
		logic armed;
		logic [1:0] unlockCnt;
		logic unlocked;
		logic selPulse;
		logic progPulse;
		logic refusedPulse;
		logic [7:0] tempOfs;
		logic [7:0] hostCfg;
		logic ifType;
		logic emuPrev;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [7:0] rdData;
		logic [3:0] twoWire;
		logic [2:0] fourWire;
		logic busy;
		logic identWr;
	} fcif_state_type;

	fcif_state_type state_reg; // Registered state
	fcif_state_type state_next; // Next state

	// Combinational decode results, registered before they reach the pins
	logic mPm, mHs, mRead, mPage, fSel, fRead, fIdle;

	// Address match against the fused base
	fcif_slave_match #(
		.DEFAULT_BASE(DEFAULT_BASE)
	) uMatch (
		.baseField(state_reg.hostCfg[BASE_HI:BASE_LO]),
		.addrByte(rxSlaveAddr),
		.addrValid(rxSlaveAddrValid),
		.pmHit(mPm),
		.hsHit(mHs),
		.isRead(mRead),
		.pageHigh(mPage)
	);

	// Four-wire polarity decode on synchronised pins
	fcif_four_wire_pol uPol (
		.selPin(state_reg.sync2[0]),
		.dirPin(state_reg.sync2[1]),
		.clkPin(state_reg.sync2[2]),
		.dirPol(state_reg.hostCfg[DIRPOL_BIT]),
		.clkPol(state_reg.hostCfg[CLKPOL_BIT]),
		.selPol(state_reg.hostCfg[SELPOL_BIT]),
		.selected(fSel),
		.isRead(fRead),
		.clkIdle(fIdle)
	);

	// Step number to fuse word
	function automatic logic [7:0] stepWord(input logic [1:0] s);
		unique case (s)
			STEP_TEMP: stepWord = FUSE_TEMP_WORD;
			STEP_HOST: stepWord = FUSE_HOST_WORD;
			STEP_CFGA: stepWord = FUSE_CFGA_WORD;
			STEP_LOCK: stepWord = FUSE_LOCK_WORD;
		endcase
	endfunction

	// Next-state logic
	always_comb
	begin
		logic locked;
		logic [7:0] rd;
		locked = 1'b0;
		rd = BYTE_RST;
		state_next = state_reg;
		state_next.selPulse = 1'b0;
		state_next.progPulse = 1'b0;
		state_next.refusedPulse = 1'b0;
		// Pins pass two flip-flops before any decode
		state_next.sync1 = {fwClkPin, fwDirPin, fwSelectPin};
		state_next.sync2 = state_reg.sync1;
		state_next.twoWire = {mPm, mHs, mRead, mPage};
		state_next.fourWire = {fSel, fRead, fIdle};
		// Falling edge of the emulation window
		state_next.emuPrev = emulatedReadActive;
		if (state_reg.emuPrev && !emulatedReadActive)
			state_next.done = 1'b0;
		// Register writes; a write setting a flag overrides the hardware clear
		if (regWrEn)
		begin
			unique case (regAddr)
				PAGE_CONTROL_OFS: state_next.page = regWrData;
				FUSE_CTRL_OFS:
				begin
					state_next.done = regWrData[DONE_BIT];
					state_next.timing = regWrData[TIMING_BIT];
					// Triggers only set here; they clear themselves when done
					if (regWrData[APP_RELOAD_BIT])
						state_next.appTrig = 1'b1;
					if (regWrData[DEV_RELOAD_BIT])
						state_next.devTrig = 1'b1;
				end
				FUSE_ADDR_OFS:
				begin
					state_next.fAddr = regWrData;
					// Writing the data value here selects this chip and arms unlock
					if (regWrData == state_reg.fData)
					begin
						state_next.selPulse = 1'b1;
						state_next.armed = 1'b1;
						state_next.unlockCnt = COUNT_RST;
						state_next.unlocked = 1'b0;
					end
					else
						state_next.armed = 1'b0;
				end
				FUSE_DATA_OFS:
				begin
					state_next.fData = regWrData;
					if (state_reg.unlocked)
					begin
						// Locked ranges never see a program strobe
						if (state_reg.fAddr <= CONF_RANGE_HI)
							locked = state_reg.locks[CONF_LOCK_BIT];
						else if (state_reg.fAddr <= APP_RANGE_HI)
							locked = state_reg.locks[APP_LOCK_BIT];
						else if (state_reg.fAddr <= DEV_RANGE_HI)
							locked = state_reg.locks[DEV_LOCK_BIT];
						state_next.progPulse = !locked;
						state_next.refusedPulse = locked;
					end
					else if (state_reg.armed)
					begin
						// Count the three unlock bytes after the select
						state_next.unlockCnt = state_reg.unlockCnt + 2'h1;
						if (state_reg.unlockCnt == UNLOCK_BYTES - 2'h1)
						begin
							state_next.unlocked = 1'b1;
							state_next.armed = 1'b0;
						end
					end
				end
				HOST_CFG_OFS:
				begin
					// Phase stays as fused; only open samples take writes
					if (unmarkedSample && !state_reg.locks[APP_LOCK_BIT])
						state_next.hostCfg = {regWrData[7:3], state_reg.hostCfg[PHASE_BIT], regWrData[1:0]};
				end
				default: ; // Read-only and unmapped offsets ignore writes
			endcase
		end
		// Reload sequencer
		unique case (state_reg.seq)
			ST_BOOT:
			begin
				// Power-on load of every fused field
				state_next.seq = ST_FETCH;
				state_next.mode = MODE_FULL;
				state_next.step = STEP_TEMP;
				state_next.req = 1'b1;
				state_next.rdAddr = stepWord(STEP_TEMP);
			end
			ST_IDLE:
			begin
				// Application reload wins if both triggers are pending
				if (state_reg.appTrig)
				begin
					state_next.seq = ST_FETCH;
					state_next.mode = MODE_APP;
					state_next.step = STEP_TEMP;
					state_next.req = 1'b1;
					state_next.rdAddr = stepWord(STEP_TEMP);
				end
				else if (state_reg.devTrig)
				begin
					state_next.seq = ST_FETCH;
					state_next.mode = MODE_DEV;
					state_next.step = STEP_LOCK;
					state_next.req = 1'b1;
					state_next.rdAddr = stepWord(STEP_LOCK);
				end
			end
			ST_FETCH:
			begin
				if (fuseRdAck)
				begin
					unique case (state_reg.step)
						STEP_TEMP: state_next.tempOfs = fuseRdData;
						STEP_HOST: state_next.hostCfg = fuseRdData;
						STEP_CFGA: state_next.ifType = fuseRdData[IF_TYPE_BIT];
						STEP_LOCK:
						begin
							if (state_reg.mode != MODE_DEV)
								state_next.locks[APP_LOCK_BIT] = fuseRdData[APP_LOCK_BIT];
							if (state_reg.mode != MODE_APP)
							begin
								state_next.locks[WRDIS_BIT] = fuseRdData[WRDIS_BIT];
								state_next.locks[DEV_LOCK_BIT] = fuseRdData[DEV_LOCK_BIT];
							end
							if (state_reg.mode == MODE_FULL)
								state_next.locks[CONF_LOCK_BIT] = fuseRdData[CONF_LOCK_BIT];
						end
					endcase
					if (state_reg.step == STEP_LOCK)
					begin
						state_next.seq = ST_IDLE;
						state_next.req = 1'b0;
						// A trigger written in this cycle starts a new reload
						if (state_reg.mode == MODE_APP && !(regWrEn && regAddr == FUSE_CTRL_OFS
							&& regWrData[APP_RELOAD_BIT]))
							state_next.appTrig = 1'b0;
						if (state_reg.mode == MODE_DEV && !(regWrEn && regAddr == FUSE_CTRL_OFS
							&& regWrData[DEV_RELOAD_BIT]))
							state_next.devTrig = 1'b0;
					end
					else
					begin
						state_next.step = state_reg.step + 2'h1;
						state_next.rdAddr = stepWord(state_reg.step + 2'h1);
					end
				end
			end
		endcase
		// Read data, captured on the read strobe
		unique case (regAddr)
			PAGE_CONTROL_OFS: rd = state_reg.page;
			FUSE_CTRL_OFS: rd = {state_reg.locks[7:4], state_reg.done, state_reg.appTrig,
				state_reg.devTrig, state_reg.timing};
			FUSE_ADDR_OFS: rd = state_reg.fAddr;
			FUSE_DATA_OFS: rd = state_reg.fData;
			TEMP_OFFSET_OFS: rd = state_reg.tempOfs;
			HOST_CFG_OFS: rd = state_reg.hostCfg;
			CFG_A_OFS: rd = {state_reg.ifType, 7'h00};
			default: rd = BYTE_RST;
		endcase
		if (regRdEn)
			state_next.rdData = rd;
		// Status outputs get their own flops so no gate sits behind the pins
		state_next.busy = (state_next.seq != ST_IDLE);
		state_next.identWr = !state_next.locks[WRDIS_BIT];
	end

	// State register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= '0;
			state_reg.seq <= ST_BOOT;
			state_reg.mode <= MODE_FULL;
			state_reg.busy <= 1'b1;
			state_reg.identWr <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state register
	assign regRdData = state_reg.rdData;
	assign fuseRdReq = state_reg.req;
	assign fuseRdAddr = state_reg.rdAddr;
	assign fuseMarginal = state_reg.timing;
	assign fuseAddrOut = state_reg.fAddr;
	assign fuseDataOut = state_reg.fData;
	assign fuseSelectPulse = state_reg.selPulse;
	assign fuseUnlocked = state_reg.unlocked;
	assign fuseProgram = state_reg.progPulse;
	assign fuseProgramRefused = state_reg.refusedPulse;
	assign reloadBusy = state_reg.busy;
	// Identification registers elsewhere take writes only when this is high
	assign identWriteEnable = state_reg.identWr;
	assign pageControl = state_reg.page;
	assign {pmHit, hsHit, slaveRead, slavePageHigh} = state_reg.twoWire;
	assign {fwSelected, fwIsRead, fwClkIdle} = state_reg.fourWire;
	assign fwClkPhase = state_reg.hostCfg[PHASE_BIT];
	assign ifTypeTwoWire = state_reg.ifType;

endmodule

//--- fcif_pkg.sv
// Shared constants for the fuse control and host port configuration page.
// Assumes an 8-bit register port with 9-bit register addresses.
package fcif_pkg;

	// Register offsets
	localparam logic [8:0] PAGE_CONTROL_OFS = 9'h100;
	localparam logic [8:0] FUSE_CTRL_OFS = 9'h101;
	localparam logic [8:0] FUSE_ADDR_OFS = 9'h102;
	localparam logic [8:0] FUSE_DATA_OFS = 9'h103;
	localparam logic [8:0] TEMP_OFFSET_OFS = 9'h104;
	localparam logic [8:0] HOST_CFG_OFS = 9'h105;
	localparam logic [8:0] CFG_A_OFS = 9'h106;

	// Fuse control and status field positions
	localparam int WRDIS_BIT = 7;
	localparam int CONF_LOCK_BIT = 6;
	localparam int APP_LOCK_BIT = 5;
	localparam int DEV_LOCK_BIT = 4;
	localparam int DONE_BIT = 3;
	localparam int APP_RELOAD_BIT = 2;
	localparam int DEV_RELOAD_BIT = 1;
	localparam int TIMING_BIT = 0;

	// Host port configuration field positions
	localparam int BASE_HI = 7;
	localparam int BASE_LO = 4;
	localparam int DIRPOL_BIT = 3;
	localparam int PHASE_BIT = 2;
	localparam int CLKPOL_BIT = 1;
	localparam int SELPOL_BIT = 0;
	localparam int IF_TYPE_BIT = 7;

	// Slave address byte layout
	localparam int HS_SEL_BIT = 2;
	localparam int PAGE_HI_BIT = 1;
	localparam int READ_BIT = 0;
	localparam logic [3:0] BASE_UNPROGRAMMED = 4'h0;

	// Values after reset
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] NIBBLE_RST = 4'h0;
	localparam logic [1:0] STEP_RST = 2'h0;
	localparam logic [1:0] COUNT_RST = 2'h0;

	// Fuse array words fetched by a reload, in step order
	localparam logic [7:0] FUSE_TEMP_WORD = 8'h00;
	localparam logic [7:0] FUSE_HOST_WORD = 8'h01;
	localparam logic [7:0] FUSE_CFGA_WORD = 8'h02;
	localparam logic [7:0] FUSE_LOCK_WORD = 8'h03;
	localparam logic [1:0] STEP_TEMP = 2'h0;
	localparam logic [1:0] STEP_HOST = 2'h1;
	localparam logic [1:0] STEP_CFGA = 2'h2;
	localparam logic [1:0] STEP_LOCK = 2'h3;

	// Fuse address ranges guarded by the three lock bits
	localparam logic [7:0] CONF_RANGE_HI = 8'h7F;
	localparam logic [7:0] APP_RANGE_HI = 8'h9F;
	localparam logic [7:0] DEV_RANGE_HI = 8'hBF;

	// Unlock sequence: one select byte then this many data bytes
	localparam logic [1:0] UNLOCK_BYTES = 2'h3;

	// Reload sequencer states
	typedef enum logic [2:0]
	{
		ST_BOOT = 3'b001,
		ST_IDLE = 3'b010,
		ST_FETCH = 3'b100
	} fcif_seq_type;

	// Which fields a reload refreshes
	typedef enum logic [2:0]
	{
		MODE_FULL = 3'b001,
		MODE_APP = 3'b010,
		MODE_DEV = 3'b100
	} fcif_mode_type;

endpackage

//--- fcif_slave_match.sv
// Two-wire slave address matcher for the power-manager and high-speed ports.
// Assumes the received address byte is from logic on the same clock.
`timescale 1ns/1ps
module fcif_slave_match
	import fcif_pkg::*;
#(
	parameter logic [3:0] DEFAULT_BASE = 4'hB
)
(
	// Configuration
	input wire logic [3:0] baseField,
	// Received address
	input wire logic [7:0] addrByte,
	input wire logic addrValid,
	// Decode
	output logic pmHit,
	output logic hsHit,
	output logic isRead,
	output logic pageHigh
);

	logic [3:0] effBase; // Base actually answered
	logic baseHit;

	// Unprogrammed fuses fall back to the hardware default base
	always_comb
	begin
		effBase = (baseField == BASE_UNPROGRAMMED) ? DEFAULT_BASE : baseField;
		baseHit = addrValid && (addrByte[7:4] == effBase) && (addrByte[3] == 1'b0);
		pmHit = baseHit && !addrByte[HS_SEL_BIT];
		hsHit = baseHit && addrByte[HS_SEL_BIT];
		isRead = addrByte[READ_BIT];
		pageHigh = addrByte[PAGE_HI_BIT];
	end

endmodule

//--- fcif_four_wire_pol.sv
// Polarity decode for the four-wire port pins.
// Assumes the pin levels were already synchronised.
`timescale 1ns/1ps
module fcif_four_wire_pol
(
	// Synchronised pins
	input wire logic selPin,
	input wire logic dirPin,
	input wire logic clkPin,
	// Configuration
	input wire logic dirPol,
	input wire logic clkPol,
	input wire logic selPol,
	// Decode
	output logic selected,
	output logic isRead,
	output logic clkIdle
);

	// Each pin is compared against its configured active or idle level
	always_comb
	begin
		selected = (selPin == selPol);
		isRead = (dirPin == dirPol);
		clkIdle = (clkPin == clkPol);
	end

endmodule

//--- fcif_assertions.sv
// Port-level checker for the fuse control page: register port, reload and unlock timing.
// Assumes it is bound to fcif_top and sees only its ports.
`timescale 1ns/1ps
module fcif_assertions
	import fcif_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [8:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	// Fuse side
	input wire logic fuseRdReq,
	input wire logic [7:0] fuseRdAddr,
	input wire logic fuseMarginal,
	input wire logic fuseRdAck,
	input wire logic [7:0] fuseAddrOut,
	input wire logic [7:0] fuseDataOut,
	input wire logic fuseSelectPulse,
	input wire logic fuseUnlocked,
	input wire logic fuseProgram,
	input wire logic fuseProgramRefused,
	// Status and decode
	input wire logic reloadBusy,
	input wire logic [7:0] pageControl,
	input wire logic [7:0] rxSlaveAddr,
	input wire logic rxSlaveAddrValid,
	input wire logic pmHit,
	input wire logic hsHit,
	input wire logic slaveRead,
	input wire logic slavePageHigh
);
	// Last address byte offered, so the decode can be tied to its cause
	logic [7:0] prevAddr_reg;
	logic prevValid_reg;

	// Capture the address byte beside the registered decode
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prevAddr_reg <= 8'h00;
			prevValid_reg <= 1'b0;
		end
		else
		begin
			prevAddr_reg <= rxSlaveAddr;
			prevValid_reg <= rxSlaveAddrValid;
		end
	end

	default clocking mainClk @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_timing_readback: assert property (
		regRdEn && !regWrEn && regAddr == FUSE_CTRL_OFS |=> regRdData[TIMING_BIT] == fuseMarginal)
		else $error("timing bit readback differs from marginal output");
	a_page_mirror: assert property (
		regRdEn && !regWrEn && regAddr == PAGE_CONTROL_OFS |=> regRdData == pageControl)
		else $error("page control readback differs from its output");
	a_app_reload_start: assert property (
		regWrEn && regAddr == FUSE_CTRL_OFS && regWrData[APP_RELOAD_BIT] && !reloadBusy
		|-> ##2 fuseRdReq && fuseRdAddr == FUSE_TEMP_WORD)
		else $error("application reload did not start at word zero");
	a_dev_reload_start: assert property (
		regWrEn && regAddr == FUSE_CTRL_OFS && regWrData[DEV_RELOAD_BIT] && !regWrData[APP_RELOAD_BIT]
		&& !reloadBusy |-> ##2 fuseRdReq && fuseRdAddr == FUSE_LOCK_WORD)
		else $error("device reload did not fetch the lock word");
	a_reload_finish: assert property (
		fuseRdReq && fuseRdAck && fuseRdAddr == FUSE_LOCK_WORD |=> !fuseRdReq && !reloadBusy)
		else $error("reload did not end after the lock word");
	a_request_held: assert property (
		fuseRdReq && !fuseRdAck |=> fuseRdReq && $stable(fuseRdAddr))
		else $error("fuse request dropped or moved before its answer");
	a_fetch_order: assert property (
		fuseRdReq && fuseRdAck && fuseRdAddr == FUSE_TEMP_WORD |=> fuseRdReq && fuseRdAddr == FUSE_HOST_WORD)
		else $error("host word not fetched after the offset word");
	a_select_match: assert property (
		regWrEn && regAddr == FUSE_ADDR_OFS && regWrData == fuseDataOut |=> fuseSelectPulse)
		else $error("matching address write gave no select pulse");
	a_select_miss: assert property (
		regWrEn && regAddr == FUSE_ADDR_OFS && regWrData != fuseDataOut |=> !fuseSelectPulse)
		else $error("select pulse on a non-matching address write");
	a_fuse_address: assert property (
		regWrEn && regAddr == FUSE_ADDR_OFS |=> fuseAddrOut == $past(regWrData))
		else $error("fuse address register missed a write");
	a_program_cause: assert property (
		fuseProgram || fuseProgramRefused |-> fuseUnlocked && $past(regWrEn) && $past(regAddr) == FUSE_DATA_OFS)
		else $error("program outcome without an unlocked data write");
	a_slave_decode: assert property (
		pmHit || hsHit |-> prevValid_reg && !prevAddr_reg[3] && pmHit != hsHit && hsHit == prevAddr_reg[HS_SEL_BIT]
		&& slaveRead == prevAddr_reg[READ_BIT] && slavePageHigh == prevAddr_reg[PAGE_HI_BIT])
		else $error("slave decode does not follow the address byte");

	c_reload_done: cover property (fuseRdReq && fuseRdAck && fuseRdAddr == FUSE_LOCK_WORD);
	c_program: cover property (fuseProgram);
	c_refused: cover property (fuseProgramRefused);
	c_hs_read: cover property (hsHit && slaveRead);
endmodule

bind fcif_top fcif_assertions u_check (.*);

//--- fcif_fuse_model.sv
// Fuse array read model answering the reload sequencer.
// Assumes one word request at a time; contents come from the bench.
`timescale 1ns/1ps
module fcif_fuse_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Read port
	input wire logic fuseRdReq,
	input wire logic [7:0] fuseRdAddr,
	output logic fuseRdAck,
	output logic [7:0] fuseRdData,
	// Array contents and answer speed
	input wire logic [3:0][7:0] words,
	input wire logic slow
);
	// Cycles waited on the current word
	logic [2:0] waitCnt;

	// Answer after a delay; between answers the data lines toggle so no stale word looks valid
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fuseRdAck <= 1'b0;
			fuseRdData <= 8'h00;
			waitCnt <= 3'h0;
		end
		else if (fuseRdReq && !fuseRdAck && waitCnt >= (slow ? 3'h5 : 3'h0))
		begin
			fuseRdAck <= 1'b1;
			fuseRdData <= words[fuseRdAddr[1:0]];
			waitCnt <= 3'h0;
		end
		else
		begin
			fuseRdAck <= 1'b0;
			fuseRdData <= ~fuseRdData;
			waitCnt <= (fuseRdReq && !fuseRdAck) ? waitCnt + 3'h1 : 3'h0;
		end
	end
endmodule

//--- fuse_control_and_host_if_config_tb.sv
// Self-checking bench for the fuse control page, acting as host on the register port.
// Assumes the fuse array model answers reload requests.
`timescale 1ns/1ps
module fuse_control_and_host_if_config_tb
	import fcif_pkg::*;
;
	// Bench-driven inputs
	logic clk, nrst, regWrEn, regRdEn, emulatedReadActive, unmarkedSample, rxSlaveAddrValid;
	logic fwSelectPin, fwDirPin, fwClkPin, slow;
	logic [8:0] regAddr;
	logic [7:0] regWrData, rxSlaveAddr;
	logic [3:0][7:0] fuseWords;
	// Design outputs
	logic [7:0] regRdData, fuseRdAddr, fuseRdData, fuseAddrOut, fuseDataOut, pageControl;
	logic fuseRdReq, fuseMarginal, fuseRdAck, fuseSelectPulse, fuseUnlocked, fuseProgram, fuseProgramRefused;
	logic reloadBusy, identWriteEnable, pmHit, hsHit, slaveRead, slavePageHigh;
	logic fwSelected, fwIsRead, fwClkIdle, fwClkPhase, ifTypeTwoWire;
	// Counters of checks and of one-cycle pulses
	int err_count = 0, comparisons = 0, selCnt = 0, progCnt = 0, refCnt = 0;

	fcif_top #(.DEFAULT_BASE(4'hB)) u_dut (.*);
	fcif_fuse_model u_fuse (.clk, .nrst, .fuseRdReq, .fuseRdAddr, .fuseRdAck, .fuseRdData, .words(fuseWords), .slow);

	// 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Pulses counted where settled
	always @(negedge clk)
	begin
		if (fuseSelectPulse === 1'b1) selCnt++;
		if (fuseProgram === 1'b1) progCnt++;
		if (fuseProgramRefused === 1'b1) refCnt++;
	end

	task automatic results();
		$display("Comparisons: %0d mismatches: %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One write: strobe held across exactly one rising edge
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clk);
		regWrEn = 1'b0;
	endtask

	// One read; data is registered at the taking edge
	task automatic rdChk(input string name, input logic [8:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(negedge clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clk);
		regRdEn = 1'b0;
		check(name, regRdData & m, exp);
	endtask

	// Bounded wait; a reload can take many array answers
	task automatic waitIdle();
		repeat (2) @(negedge clk);
		for (int i = 0; i < 200 && reloadBusy !== 1'b0; i++)
			@(negedge clk);
		check("reloadBusy", reloadBusy, 8'h00);
	endtask

	task automatic doReset();
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		waitIdle();
	endtask

	task automatic probe(input logic [7:0] a, input logic pm, input logic hs);
		@(negedge clk);
		rxSlaveAddr = a;
		rxSlaveAddrValid = 1'b1;
		@(negedge clk);
		rxSlaveAddrValid = 1'b0;
		check("pmHit", pmHit, pm);
		check("hsHit", hsHit, hs);
		check("slaveRead", slaveRead & (pm | hs), a[READ_BIT] & (pm | hs));
		check("slavePageHigh", slavePageHigh & (pm | hs), a[PAGE_HI_BIT] & (pm | hs));
	endtask

	// Select byte equal to the data register, then three unlock bytes
	task automatic unlock();
		int s0;
		s0 = selCnt;
		wr(FUSE_DATA_OFS, 8'hA5);
		wr(FUSE_ADDR_OFS, 8'hA5);
		for (int i = 1; i <= 3; i++)
			wr(FUSE_DATA_OFS, 8'(17 * i));
		check("select pulses", 8'(selCnt - s0), 8'h01);
		check("fuseUnlocked", fuseUnlocked, 8'h01);
	endtask

	task automatic fuseWrite(input logic [7:0] a, input logic ok);
		int p0, r0;
		p0 = progCnt;
		r0 = refCnt;
		wr(FUSE_ADDR_OFS, a);
		wr(FUSE_DATA_OFS, 8'h5A);
		@(negedge clk);
		check("fuseAddrOut", fuseAddrOut, a);
		check("program pulses", 8'(progCnt - p0), {7'h00, ok});
		check("refused pulses", 8'(refCnt - r0), {7'h00, !ok});
	endtask

	initial
	begin
		{regAddr, regWrData, regWrEn, regRdEn, emulatedReadActive, unmarkedSample} = '0;
		{rxSlaveAddr, rxSlaveAddrValid, fwSelectPin, fwDirPin, fwClkPin} = '0;
		fuseWords = {8'h00, 8'h80, 8'hAF, 8'h9C};
		slow = 1'b1;
		doReset();
		// Power-on load of all four words
		rdChk("offset", TEMP_OFFSET_OFS, 8'hFF, 8'h9C);
		rdChk("host cfg", HOST_CFG_OFS, 8'hFF, 8'hAF);
		rdChk("cfg A", CFG_A_OFS, 8'hFF, 8'h80);
		rdChk("fuse ctrl", FUSE_CTRL_OFS, 8'hFF, 8'h00);
		check("ifTypeTwoWire", ifTypeTwoWire, 8'h01);
		check("fwClkPhase", fwClkPhase, 8'h01);
		check("identWriteEnable", identWriteEnable, 8'h01);
		// Page control, read-only and unmapped places
		wr(PAGE_CONTROL_OFS, 8'hC5);
		rdChk("page ctrl", PAGE_CONTROL_OFS, 8'hFF, 8'hC5);
		check("pageControl", pageControl, 8'hC5);
		wr(TEMP_OFFSET_OFS, 8'h00);
		rdChk("offset", TEMP_OFFSET_OFS, 8'hFF, 8'h9C);
		wr(CFG_A_OFS, 8'h00);
		rdChk("cfg A", CFG_A_OFS, 8'hFF, 8'h80);
		rdChk("unmapped", 9'h107, 8'hFF, 8'h00);
		// Timing select, then done bit set by software and cleared on leaving emulation
		wr(FUSE_CTRL_OFS, 8'h01);
		check("fuseMarginal", fuseMarginal, 8'h01);
		rdChk("timing", FUSE_CTRL_OFS, 8'h01, 8'h01);
		emulatedReadActive = 1'b1;
		wr(FUSE_CTRL_OFS, 8'h08);
		check("fuseMarginal", fuseMarginal, 8'h00);
		rdChk("done", FUSE_CTRL_OFS, 8'h08, 8'h08);
		emulatedReadActive = 1'b0;
		repeat (2) @(negedge clk);
		rdChk("done", FUSE_CTRL_OFS, 8'h08, 8'h00);
		// Host configuration: bit 2 keeps its fused value; marked samples refused
		unmarkedSample = 1'b1;
		wr(HOST_CFG_OFS, 8'h58);
		rdChk("host cfg", HOST_CFG_OFS, 8'hFF, 8'h5C);
		unmarkedSample = 1'b0;
		wr(HOST_CFG_OFS, 8'h00);
		rdChk("host cfg", HOST_CFG_OFS, 8'hFF, 8'h5C);
		probe(8'h52, 1'b1, 1'b0);
		probe(8'hB2, 1'b0, 1'b0);
		// Four-wire polarities, each against both pin levels
		unmarkedSample = 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			wr(HOST_CFG_OFS, {4'h0, p[0], 1'b0, p[0], p[0]});
			for (int v = 0; v < 2; v++)
			begin
				{fwSelectPin, fwDirPin, fwClkPin} = {3{v[0]}};
				repeat (4) @(negedge clk);
				check("fwSelected", fwSelected, v == p);
				check("fwIsRead", fwIsRead, v == p);
				check("fwClkIdle", fwClkIdle, v == p);
			end
		end
		// Base field now 0000: default base answers all eight codes
		for (int i = 0; i < 8; i++)
			probe(8'hB0 | 8'(i), i < 4, i >= 4);
		// Application reload from a slow array
		fuseWords[3] = 8'h20;
		fuseWords[0] = 8'h7F;
		wr(FUSE_CTRL_OFS, 8'h04);
		rdChk("app trigger", FUSE_CTRL_OFS, 8'h04, 8'h04);
		waitIdle();
		rdChk("fuse ctrl", FUSE_CTRL_OFS, 8'hFF, 8'h20);
		rdChk("offset", TEMP_OFFSET_OFS, 8'hFF, 8'h7F);
		rdChk("host cfg", HOST_CFG_OFS, 8'hFF, 8'hAF);
		wr(HOST_CFG_OFS, 8'h00);
		rdChk("host cfg", HOST_CFG_OFS, 8'hFF, 8'hAF);
		// Device reload from a prompt array leaves the offset alone
		slow = 1'b0;
		fuseWords[3] = 8'hB0;
		fuseWords[0] = 8'h80;
		wr(FUSE_CTRL_OFS, 8'h02);
		waitIdle();
		rdChk("fuse ctrl", FUSE_CTRL_OFS, 8'hFF, 8'hB0);
		rdChk("offset", TEMP_OFFSET_OFS, 8'hFF, 8'h7F);
		check("identWriteEnable", identWriteEnable, 8'h00);
		// Programming against the lock ranges
		unlock();
		fuseWrite(8'h10, 1'b1);
		fuseWrite(8'h90, 1'b0);
		fuseWrite(8'hB0, 1'b0);
		fuseWrite(8'hF0, 1'b1);
		rdChk("fuse addr", FUSE_ADDR_OFS, 8'hFF, 8'hF0);
		rdChk("fuse data", FUSE_DATA_OFS, 8'hFF, 8'h5A);
		// Second reset with every lock fused
		fuseWords[3] = 8'hF0;
		doReset();
		rdChk("fuse ctrl", FUSE_CTRL_OFS, 8'hFF, 8'hF0);
		rdChk("offset", TEMP_OFFSET_OFS, 8'hFF, 8'h80);
		unlock();
		fuseWrite(8'h10, 1'b0);
		results();
	end

	// Watchdog far past the run length
	initial
	begin
		#(20 * 20000);
		err_count++;
		results();
	end
endmodule
